// ### logic/txcad_pkg.sv
// Constants and types shared by the transmit command A decoder
`default_nettype none
package txcad_pkg;
   // Command A field positions
   localparam int unsigned ALIGN_HI   = 25;           // End-alignment code, high bit
   localparam int unsigned ALIGN_LO   = 24;           // End-alignment code, low bit
   localparam int unsigned OFS_HI     = 20;           // Start offset, high bit
   localparam int unsigned OFS_LO     = 16;           // Start offset, low bit
   localparam int unsigned FIRST_BIT  = 13;           // First-segment marker
   localparam int unsigned LAST_BIT   = 12;           // Last-segment marker
   localparam int unsigned SIZE_HI    = 10;           // Byte count / packet length top bit
   localparam logic [31:0] RSVD_MASK  = 32'h00E0C800; // Bits 23:21, 15:14, 11
   // End-alignment codes
   localparam logic [1:0]  ALIGN_4    = 2'h0;         // 4-byte
   localparam logic [1:0]  ALIGN_16   = 2'h1;         // 16-byte
   localparam logic [1:0]  ALIGN_32   = 2'h2;         // 32-byte
   localparam logic [1:0]  ALIGN_RSVD = 2'h3;         // Not to be used
   // Register byte offsets
   localparam logic [7:0]  CTRL_OFS   = 8'h00;        // Control
   localparam logic [7:0]  STAT_OFS   = 8'h04;        // Sticky status, read only
   localparam logic [7:0]  CLR_OFS    = 8'h08;        // Status clear, write only
   localparam logic [7:0]  IEN_OFS    = 8'h0C;        // Interrupt enable
   localparam logic [7:0]  CMDA_OFS   = 8'h10;        // Last command A, read only
   localparam logic [7:0]  TOTAL_OFS  = 8'h14;        // Running byte total, read only
   // Reset values
   localparam logic        CTRL_RST   = 1'b1;         // Decoder enabled
   localparam logic [2:0]  IEN_RST    = 3'h0;         // All interrupts masked
   // Status bit positions
   localparam int unsigned ST_ERR     = 0;            // Length mismatch
   localparam int unsigned ST_DONE    = 1;            // Packet closed
   localparam int unsigned ST_BAD     = 2;            // Reserved field used
   // AXI responses
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;
   // Parser states, Gray along the usual path
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CMDB = 3'h1,
      ST_SKIP = 3'h3,
      ST_DATA = 3'h2,
      ST_PAD  = 3'h6
   } txcad_state_type;
endpackage : txcad_pkg
`default_nettype wire

// ### logic/txcad_span.sv
// Buffer geometry from offset, byte count and end alignment
`default_nettype none
module txcad_span (
   input  wire logic [4:0]  offset_i,    // Start offset in bytes
   input  wire logic [10:0] size_i,      // Buffer byte count
   input  wire logic [1:0]  align_i,     // End-alignment code
   output logic      [11:0] skip_o,      // Whole dwords before data
   output logic      [11:0] data_end_o,  // Dword index after last data dword
   output logic      [11:0] total_end_o, // Dword index after padding
   output logic      [3:0]  first_be_o,  // Lanes of first data dword
   output logic      [3:0]  last_be_o    // Lanes of last data dword
);
   logic [11:0] end_byte; // Offset plus size
   logic [11:0] last_byte; // Index of last valid byte

   // Geometry, padding counted from the start of the data area
   always_comb begin
      end_byte  = {7'h00, offset_i} + {1'b0, size_i};
      last_byte = end_byte - 12'h001;
      skip_o    = {9'h000, offset_i[4:2]};
      // Empty buffer carries no data dword
      data_end_o = (size_i == 11'h000) ? skip_o : 12'((end_byte + 12'h003) >> 2);
      unique case (align_i)
         txcad_pkg::ALIGN_16 : total_end_o = (data_end_o + 12'h003) & 12'hFFC;
         txcad_pkg::ALIGN_32 : total_end_o = (data_end_o + 12'h007) & 12'hFF8;
         default             : total_end_o = data_end_o; // 4-byte or reserved
      endcase
      // Low offset bits pick the first lane [RULE11]
      unique case (offset_i[1:0])
         2'h0    : first_be_o = 4'hF;
         2'h1    : first_be_o = 4'hE;
         2'h2    : first_be_o = 4'hC;
         default : first_be_o = 4'h8;
      endcase
      unique case (last_byte[1:0])
         2'h0    : last_be_o = 4'h1;
         2'h1    : last_be_o = 4'h3;
         2'h2    : last_be_o = 4'h7;
         default : last_be_o = 4'hF;
      endcase
   end
endmodule : txcad_span
`default_nettype wire

// ### logic/txcad_decoder.sv
// Transmit command A decoder with AXI4-Lite registers
// Behaviour
// [RULE1] Host writes zero to all reserved bits
// [RULE2] Bits 20:16 give start offset 0-31
// [RULE3] Bit 13 opens a new packet
// [RULE4] Bit 12 closes the current packet
// [RULE5] Bits 10:0 give buffer byte count
// [RULE6] Count plus alignment gives padding, discarded
// [RULE7] Per-packet total mismatch raises the error flag
// [RULE8] Byte count excludes offset and padding bytes
// [RULE9] Alignment code: 4, 16, 32 bytes, reserved
// [RULE10] Compare total with command B length
// [RULE11] Low offset bits pick the first lane
// [RULE12] First clears total, last triggers compare
`default_nettype none
module txcad_decoder (
   input  wire logic        SYS_CLK_I,       // 20 MHz clock
   input  wire logic        ARST_N_I,        // Async reset, active low
   input  wire logic [31:0] IN_DATA_I,       // Buffer word stream
   input  wire logic        IN_VALID_I,      // Word offered
   output logic             IN_READY_O,      // Word taken
   output logic      [31:0] OUT_DATA_O,      // Data dword
   output logic      [3:0]  OUT_BE_O,        // Valid byte lanes
   output logic             OUT_FIRST_O,     // First dword of packet
   output logic             OUT_LAST_O,      // Last dword of packet
   output logic             OUT_VALID_O,     // Data offered
   input  wire logic        OUT_READY_I,     // Data taken
   output logic             TX_ERROR_FLAG_O, // Length mismatch pulse
   output logic             IRQ_O,           // Level interrupt
   input  wire logic [7:0]  AXI_AWADDR_I,
   input  wire logic        AXI_AWVALID_I,
   output logic             AXI_AWREADY_O,
   input  wire logic [31:0] AXI_WDATA_I,
   input  wire logic [3:0]  AXI_WSTRB_I,
   input  wire logic        AXI_WVALID_I,
   output logic             AXI_WREADY_O,
   output logic      [1:0]  AXI_BRESP_O,
   output logic             AXI_BVALID_O,
   input  wire logic        AXI_BREADY_I,
   input  wire logic [7:0]  AXI_ARADDR_I,
   input  wire logic        AXI_ARVALID_I,
   output logic             AXI_ARREADY_O,
   output logic      [31:0] AXI_RDATA_O,
   output logic      [1:0]  AXI_RRESP_O,
   output logic             AXI_RVALID_O,
   input  wire logic        AXI_RREADY_I
);
   txcad_pkg::txcad_state_type state_reg, state_next; // Parser state
   logic [31:0] cmd_a_reg;      // Latched command A
   logic [11:0] cnt_reg;        // Dword position in data area
   logic [11:0] cnt_inc;        // Position after this word
   logic [11:0] total_reg;      // Running packet byte total
   logic [11:0] sum;            // Total including this buffer
   logic [11:0] skip;           // Dwords skipped by offset
   logic [11:0] data_end;       // End of data dwords
   logic [11:0] total_end;      // End of padding dwords
   logic [3:0]  first_be;       // First dword lanes
   logic [3:0]  last_be;        // Last dword lanes
   logic        acc;            // Input word taken
   logic        enable_reg;     // Decoder enable
   logic [2:0]  status_reg;     // Sticky events
   logic [2:0]  ien_reg;        // Interrupt enables
   logic [2:0]  events;         // Event pulses this cycle
   logic        err_reg;        // Error pulse
   logic        aw_held_reg;    // Write address captured
   logic        w_held_reg;     // Write data captured
   logic [7:0]  awaddr_reg;     // Captured write address
   logic [31:0] wdata_reg;      // Captured write data
   logic        wstrb0_reg;     // Low byte strobe
   logic        wr_do;          // Register write this cycle
   logic        wr_hit;         // Write address mapped

   // Geometry of the current buffer
   txcad_span u_span (
      .offset_i    (cmd_a_reg[txcad_pkg::OFS_HI:txcad_pkg::OFS_LO]), // [RULE2]
      .size_i      (cmd_a_reg[txcad_pkg::SIZE_HI:0]),                // [RULE5] [RULE8]
      .align_i     (cmd_a_reg[txcad_pkg::ALIGN_HI:txcad_pkg::ALIGN_LO]), // [RULE9]
      .skip_o      (skip),
      .data_end_o  (data_end),
      .total_end_o (total_end),
      .first_be_o  (first_be),
      .last_be_o   (last_be)
   );

   // Stall input while data output is blocked or decoder is off
   assign IN_READY_O = enable_reg && !(state_reg == txcad_pkg::ST_DATA && OUT_VALID_O && !OUT_READY_I);
   assign acc        = IN_VALID_I && IN_READY_O;
   assign cnt_inc    = (state_reg == txcad_pkg::ST_CMDB) ? 12'h000 : cnt_reg + 12'h001;
   // First segment restarts the total [RULE12] [RULE3]
   assign sum        = (cmd_a_reg[txcad_pkg::FIRST_BIT] ? 12'h000 : total_reg)
                       + {1'b0, cmd_a_reg[txcad_pkg::SIZE_HI:0]};

   // Next state from the position reached
   always_comb begin
      state_next = state_reg;
      if (acc) begin
         if (state_reg == txcad_pkg::ST_IDLE) begin
            state_next = txcad_pkg::ST_CMDB;
         end else if (cnt_inc >= total_end) begin
            state_next = txcad_pkg::ST_IDLE;
         end else if (cnt_inc >= data_end) begin
            state_next = txcad_pkg::ST_PAD;  // Padding dwords are dropped [RULE6]
         end else if (cnt_inc >= skip) begin
            state_next = txcad_pkg::ST_DATA;
         end else begin
            state_next = txcad_pkg::ST_SKIP; // Whole offset dwords [RULE2]
         end
      end
   end

   // Parser state and position
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_reg <= txcad_pkg::ST_IDLE;
         cnt_reg   <= 12'h000;
      end else begin
         state_reg <= state_next;
         if (acc) begin
            cnt_reg <= cnt_inc;
         end
      end
   end

   // Command A capture
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cmd_a_reg <= 32'h00000000;
      end else if (acc && state_reg == txcad_pkg::ST_IDLE) begin
         cmd_a_reg <= IN_DATA_I;
      end
   end

   // Packet total and length check on command B
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         total_reg <= 12'h000;
         err_reg   <= 1'b0;
      end else begin
         err_reg <= 1'b0;
         if (acc && state_reg == txcad_pkg::ST_CMDB) begin
            total_reg <= sum; // [RULE7]
            if (cmd_a_reg[txcad_pkg::LAST_BIT]) begin
               err_reg <= (sum != {1'b0, IN_DATA_I[txcad_pkg::SIZE_HI:0]}); // [RULE10] [RULE12] [RULE4]
            end
         end
      end
   end
   assign TX_ERROR_FLAG_O = err_reg;

   // Data dword output with lane masks
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         OUT_DATA_O  <= 32'h00000000;
         OUT_BE_O    <= 4'h0;
         OUT_FIRST_O <= 1'b0;
         OUT_LAST_O  <= 1'b0;
         OUT_VALID_O <= 1'b0;
      end else if (acc && state_reg == txcad_pkg::ST_DATA) begin
         OUT_DATA_O  <= IN_DATA_I;
         OUT_BE_O    <= ((cnt_reg == skip) ? first_be : 4'hF)
                        & ((cnt_reg == data_end - 12'h001) ? last_be : 4'hF); // [RULE11]
         OUT_FIRST_O <= cmd_a_reg[txcad_pkg::FIRST_BIT] && cnt_reg == skip;  // [RULE3]
         OUT_LAST_O  <= cmd_a_reg[txcad_pkg::LAST_BIT]
                        && cnt_reg == data_end - 12'h001;                  // [RULE4]
         OUT_VALID_O <= 1'b1;
      end else if (OUT_READY_I) begin
         OUT_VALID_O <= 1'b0;
      end
   end

   // Events: error, packet closed, reserved field in command A
   assign events = {acc && state_reg == txcad_pkg::ST_CMDB
                    && ((cmd_a_reg & txcad_pkg::RSVD_MASK) != 32'h00000000 // [RULE1]
                        || cmd_a_reg[txcad_pkg::ALIGN_HI:txcad_pkg::ALIGN_LO] == txcad_pkg::ALIGN_RSVD),
                    acc && state_reg == txcad_pkg::ST_CMDB && cmd_a_reg[txcad_pkg::LAST_BIT],
                    err_reg};

   // Sticky status, set wins over clear
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         status_reg <= 3'h0;
      end else begin
         status_reg <= events
                       | (status_reg & ~((wr_do && wstrb0_reg && awaddr_reg == txcad_pkg::CLR_OFS)
                                         ? wdata_reg[2:0] : 3'h0));
      end
   end
   assign IRQ_O = |(status_reg & ien_reg);

   // Write channel capture
   assign AXI_AWREADY_O = !aw_held_reg && !AXI_BVALID_O;
   assign AXI_WREADY_O  = !w_held_reg && !AXI_BVALID_O;
   assign wr_do         = aw_held_reg && w_held_reg && !AXI_BVALID_O;
   assign wr_hit        = awaddr_reg == txcad_pkg::CTRL_OFS || awaddr_reg == txcad_pkg::CLR_OFS
                          || awaddr_reg == txcad_pkg::IEN_OFS;
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         awaddr_reg   <= 8'h00;
         wdata_reg    <= 32'h00000000;
         wstrb0_reg   <= 1'b0;
         AXI_BVALID_O <= 1'b0;
         AXI_BRESP_O  <= txcad_pkg::RESP_OKAY;
      end else begin
         if (AXI_AWVALID_I && AXI_AWREADY_O) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= {AXI_AWADDR_I[7:2], 2'h0};
         end
         if (AXI_WVALID_I && AXI_WREADY_O) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= AXI_WDATA_I;
            wstrb0_reg <= AXI_WSTRB_I[0];
         end
         if (wr_do) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            AXI_BVALID_O <= 1'b1;
            AXI_BRESP_O  <= wr_hit ? txcad_pkg::RESP_OKAY : txcad_pkg::RESP_SLV;
         end else if (AXI_BREADY_I) begin
            AXI_BVALID_O <= 1'b0;
         end
      end
   end

   // Writable registers, low byte only
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         enable_reg <= txcad_pkg::CTRL_RST;
         ien_reg    <= txcad_pkg::IEN_RST;
      end else if (wr_do && wstrb0_reg) begin
         if (awaddr_reg == txcad_pkg::CTRL_OFS) begin
            enable_reg <= wdata_reg[0];
         end
         if (awaddr_reg == txcad_pkg::IEN_OFS) begin
            ien_reg <= wdata_reg[2:0];
         end
      end
   end

   // Read channel, answer one cycle after the address
   assign AXI_ARREADY_O = !AXI_RVALID_O;
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         AXI_RVALID_O <= 1'b0;
         AXI_RDATA_O  <= 32'h00000000;
         AXI_RRESP_O  <= txcad_pkg::RESP_OKAY;
      end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
         AXI_RVALID_O <= 1'b1;
         AXI_RRESP_O  <= txcad_pkg::RESP_OKAY;
         unique case ({AXI_ARADDR_I[7:2], 2'h0})
            txcad_pkg::CTRL_OFS  : AXI_RDATA_O <= {31'h0, enable_reg};
            txcad_pkg::STAT_OFS  : AXI_RDATA_O <= {29'h0, status_reg};
            txcad_pkg::IEN_OFS   : AXI_RDATA_O <= {29'h0, ien_reg};
            txcad_pkg::CMDA_OFS  : AXI_RDATA_O <= cmd_a_reg;
            txcad_pkg::TOTAL_OFS : AXI_RDATA_O <= {20'h00000, total_reg};
            default : begin
               AXI_RDATA_O <= 32'h00000000; // Unmapped or write-only
               AXI_RRESP_O <= txcad_pkg::RESP_SLV;
            end
         endcase
      end else if (AXI_RREADY_I) begin
         AXI_RVALID_O <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!ARST_N_I);

   sequence cmdb_last_s;
      acc && state_reg == txcad_pkg::ST_CMDB && cmd_a_reg[txcad_pkg::LAST_BIT];
   endsequence
   sequence cmdb_first_s;
      acc && state_reg == txcad_pkg::ST_CMDB && cmd_a_reg[txcad_pkg::FIRST_BIT];
   endsequence

   skip_region_a : assert property (state_reg == txcad_pkg::ST_DATA |-> cnt_reg >= skip) // [RULE2]
      else $error("Data taken inside offset dwords");
   first_total_a : assert property (cmdb_first_s |=> total_reg == {1'b0, $past(cmd_a_reg[10:0])}) // [RULE3]
      else $error("First segment did not restart total");
   last_mark_a : assert property (acc && state_reg == txcad_pkg::ST_DATA && cnt_reg == data_end - 12'h001
         && cmd_a_reg[txcad_pkg::LAST_BIT] |=> OUT_VALID_O && OUT_LAST_O) // [RULE4]
      else $error("Last dword not marked");
   data_count_a : assert property (state_reg == txcad_pkg::ST_CMDB && cmd_a_reg[10:0] != 11'h000
         |-> data_end == 12'((12'(cmd_a_reg[20:16]) + 12'(cmd_a_reg[10:0]) + 12'h003) >> 2)) // [RULE5]
      else $error("Data dword count wrong");
   pad_drop_a : assert property (acc && state_reg == txcad_pkg::ST_PAD |=> !$rose(OUT_VALID_O)) // [RULE6]
      else $error("Padding dword forwarded");
   len_error_a : assert property (cmdb_last_s ##0 (sum != {1'b0, IN_DATA_I[10:0]})
         |=> TX_ERROR_FLAG_O ##1 status_reg[txcad_pkg::ST_ERR]) // [RULE7] [RULE10]
      else $error("Length mismatch not flagged");
   len_match_a : assert property (cmdb_last_s ##0 (sum == {1'b0, IN_DATA_I[10:0]}) |=> !TX_ERROR_FLAG_O) // [RULE12]
      else $error("False length error");
   align_32_a : assert property (state_reg == txcad_pkg::ST_CMDB
         && cmd_a_reg[25:24] == txcad_pkg::ALIGN_32 |-> total_end[2:0] == 3'h0) // [RULE9]
      else $error("32-byte alignment not kept");
   lane_top_a : assert property (acc && state_reg == txcad_pkg::ST_DATA && cnt_reg == skip
         && cmd_a_reg[17:16] == 2'h3 |=> OUT_BE_O[2:0] == 3'h0) // [RULE11]
      else $error("Wrong first lane");
endmodule : txcad_decoder
`default_nettype wire

// ### sim/txcad_host_model.sv
// Host-side model that writes transmit buffers into the word stream
`default_nettype none
module txcad_host_model (
   input  wire logic        clk_i,    // Device clock
   input  wire logic        arst_n_i, // Async reset, active low
   input  wire logic        ready_i,  // Word taken
   input  wire logic        slow_i,   // Hold back the next word
   output logic      [31:0] data_o,   // Word on the bus
   output logic             valid_o,  // Word offered
   output logic             idle_o    // Nothing left to send
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] words[$]; // Words waiting to go out
   logic [31:0] last_a;   // Most recent command A
   assign idle_o = (words.size() == 0) && !valid_o;
   // Builds one buffer: command A, command B, offset, data, padding
   task automatic send_buf(input int ofs, size, align, input bit first, last, input int plen, base);
      int n;
      int p;
      logic [31:0] w;
      n = (ofs + size + 3) / 4;
      if (align == 1) n = (n + 3) / 4 * 4;
      else if (align == 2) n = (n + 7) / 8 * 8;
      last_a = {6'h00, 2'(align), 3'h0, 5'(ofs), 2'h0, first, last, 1'h0, 11'(size)};
      words.push_back(last_a);
      words.push_back({21'h000000, 11'(plen)});
      for (int d = 0; d < n; d++) begin
         for (int l = 0; l < 4; l++) begin
            p = 4 * d + l - ofs;
            // Data byte, or filler that must never be forwarded
            w[8*l +: 8] = (p >= 0 && p < size) ? 8'(base + p) : 8'(8'hA5 ^ p);
         end
         words.push_back(w);
      end
   endtask : send_buf
   // Offers the next word and holds it until taken
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         valid_o <= 1'b0;
         data_o  <= 32'h00000000;
      end else if (valid_o && !ready_i) begin
         valid_o <= 1'b1; // Holding
      end else if (words.size() != 0 && !slow_i) begin
         valid_o <= 1'b1;
         data_o  <= words.pop_front();
      end else begin
         valid_o <= 1'b0;
         data_o  <= ~data_o; // Released bus inverts every bit each idle cycle
      end
   end
endmodule : txcad_host_model
`default_nettype wire

// ### sim/tx_buffer_command_a_decoder_tb.sv
// Self-checking bench for the transmit command A decoder
`default_nettype none
module tx_buffer_command_a_decoder_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, arst_n, in_valid, in_ready, out_ready, slow, idle, rnd_on;
   logic [31:0] in_data, out_data, wdata, rdata;
   logic [3:0]  out_be, wstrb;
   logic        out_first, out_last, out_valid, err, irq;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   logic [37:0] exp_q[$]; // Expected {first, last, lanes, data}
   logic [37:0] exp_w;    // Entry being compared
   logic [2:0]  status_exp;
   int          mismatches, samples_checked, seed, total, err_exp, err_seen;
   int          nseg, plen, sz[3];
   // Clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   txcad_decoder DUT (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .IN_DATA_I(in_data), .IN_VALID_I(in_valid),
      .IN_READY_O(in_ready), .OUT_DATA_O(out_data), .OUT_BE_O(out_be), .OUT_FIRST_O(out_first),
      .OUT_LAST_O(out_last), .OUT_VALID_O(out_valid), .OUT_READY_I(out_ready), .TX_ERROR_FLAG_O(err),
      .IRQ_O(irq), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
      .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
      .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
      .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
      .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready));
   txcad_host_model host (.clk_i(clk), .arst_n_i(arst_n), .ready_i(in_ready), .slow_i(slow),
      .data_o(in_data), .valid_o(in_valid), .idle_o(idle));
   // Counts a comparison and reports a difference
   task automatic check(input logic [63:0] got, input logic [63:0] want, input string what);
      samples_checked++;
      if (got !== want) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask : check
   // Byte lanes to bit mask
   function automatic logic [31:0] lanes(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lanes
   // Register write, both channels offered together
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      // Waits for the answer; only the watchdog ends a hang
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check(bresp, r, "write response");
      @(posedge clk);
   endtask : axi_wr
   // Register read with expected data and response
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      // Waits for the answer; only the watchdog ends a hang
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      check({rresp, rdata}, {r, d}, "read");
      @(posedge clk);
   endtask : axi_rd
   // Sends one buffer and records what must come out
   task automatic send(input int ofs, size, align, input bit first, last, input int pl);
      int p;
      int base;
      logic [31:0] w;
      logic [3:0] be;
      base = $random(seed) & 255;
      host.send_buf(ofs, size, align, first, last, pl, base);
      if (first) total = 0;
      total += size;
      if (last) status_exp[1] = 1'b1;
      if (last && total != pl) begin
         err_exp++;
         status_exp[0] = 1'b1;
      end
      if (align == 3) status_exp[2] = 1'b1;
      for (int d = ofs / 4; d < (ofs + size + 3) / 4; d++) begin
         be = 4'h0;
         w  = 32'h00000000;
         for (int l = 0; l < 4; l++) begin
            p = 4 * d + l - ofs;
            if (p >= 0 && p < size) begin
               be[l]      = 1'b1;
               w[8*l +: 8] = 8'(base + p);
            end
         end
         exp_q.push_back({first && d == ofs / 4, last && d == (ofs + size + 3) / 4 - 1, be, w});
      end
   endtask : send
   // Waits for the stream to settle, then checks counts
   task automatic drain();
      for (int t = 0; t < 3000 && !(idle && exp_q.size() == 0); t++) @(posedge clk);
      repeat (4) @(posedge clk);
      check(exp_q.size(), 0, "dwords missing");
      check(idle, 1, "stream not drained");
      check(err_seen, err_exp, "error pulses");
   endtask : drain
   // Prints the verdict and stops
   task automatic complete_run();
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   // Random stalls on both sides of the stream
   always @(posedge clk) begin
      slow      <= rnd_on && ($random(seed) % 3 == 0);
      out_ready <= !rnd_on || ($random(seed) % 3 != 0);
   end
   // Compares each forwarded dword and counts error pulses
   always @(posedge clk) begin
      if (arst_n && err) err_seen++;
      if (arst_n && out_valid && out_ready) begin
         exp_w = exp_q.size() ? exp_q.pop_front() : 38'h3FFFFFFFFF;
         check({out_first, out_last, out_be, out_data & lanes(out_be)}, exp_w, "dword");
      end
   end
   // Watchdog
   initial begin
      #3000000;
      mismatches++;
      complete_run();
   end
   // Main sequence
   initial begin
      {arst_n, awvalid, wvalid, bready, arvalid, rready, rnd_on} = 7'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      seed = 51904;
      status_exp = 3'h0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      axi_rd(txcad_pkg::CTRL_OFS, 32'h00000001, txcad_pkg::RESP_OKAY);
      axi_rd(txcad_pkg::IEN_OFS, 32'h00000000, txcad_pkg::RESP_OKAY);
      axi_rd(txcad_pkg::STAT_OFS, 32'h00000000, txcad_pkg::RESP_OKAY);
      axi_rd(txcad_pkg::CLR_OFS, 32'h00000000, txcad_pkg::RESP_SLV);
      axi_rd(8'h40, 32'h00000000, txcad_pkg::RESP_SLV);
      axi_wr(8'h40, 32'h00000007, txcad_pkg::RESP_SLV);
      axi_wr(txcad_pkg::IEN_OFS, 32'h00000007, txcad_pkg::RESP_OKAY);
      send(0, 4, 0, 1, 1, 4);
      drain();
      axi_rd(txcad_pkg::TOTAL_OFS, 32'h00000004, txcad_pkg::RESP_OKAY);
      axi_rd(txcad_pkg::CMDA_OFS, host.last_a, txcad_pkg::RESP_OKAY);
      axi_rd(txcad_pkg::STAT_OFS, 32'(status_exp), txcad_pkg::RESP_OKAY);
      check(irq, 1, "irq raised");
      axi_wr(txcad_pkg::CLR_OFS, 32'h00000007, txcad_pkg::RESP_OKAY);
      status_exp = 3'h0;
      check(irq, 0, "irq cleared");
      send(30, 3, 2, 1, 1, 2);
      drain();
      axi_rd(txcad_pkg::STAT_OFS, 32'(status_exp), txcad_pkg::RESP_OKAY);
      axi_wr(txcad_pkg::IEN_OFS, 32'h00000000, txcad_pkg::RESP_OKAY);
      check(irq, 0, "irq masked");
      axi_wr(txcad_pkg::CLR_OFS, 32'h00000007, txcad_pkg::RESP_OKAY);
      status_exp = 3'h0;
      send(5, 9, 3, 1, 1, 9);
      drain();
      axi_rd(txcad_pkg::STAT_OFS, 32'(status_exp), txcad_pkg::RESP_OKAY);
      rnd_on <= 1'b1;
      for (int k = 0; k < 12; k++) begin
         nseg = 1 + $unsigned($random(seed)) % 3;
         plen = k % 3 == 0;
         for (int s = 0; s < nseg; s++) begin
            sz[s] = 4 + $unsigned($random(seed)) % 40;
            plen += sz[s];
         end
         for (int s = 0; s < nseg; s++)
            send($unsigned($random(seed)) % 32, sz[s], k % 3, s == 0, s == nseg - 1, plen);
      end
      drain();
      rnd_on <= 1'b0;
      axi_wr(txcad_pkg::CTRL_OFS, 32'h00000000, txcad_pkg::RESP_OKAY);
      check(in_ready, 0, "stream refused while off");
      axi_wr(txcad_pkg::CTRL_OFS, 32'h00000001, txcad_pkg::RESP_OKAY);
      check(in_ready, 1, "stream open again");
      complete_run();
   end
endmodule : tx_buffer_command_a_decoder_tb
`default_nettype wire
